// ===== src/dcss_top.sv
// Command interpreter for block size, sector format, sleep and monitoring commands.
`include "dcss_defines.svh"
module dcss_top
  import dcss_pkg::*;
#(
  parameter int ATTR_WORDS = `DCSS_ATTR_WORDS
) (
  // Clock and reset
  input  wire logic            CORE_CLK,
  input  wire logic            RSTN,
  input  wire logic            SOFT_RESET,
  // Task-file command
  input  wire logic            CMD_STROBE,
  input  wire dcss_cmd_t       CMD,
  // Task-file answer
  output logic [7:0]           ERROR_FLAGS,
  output logic [7:0]           STATUS_FLAGS,
  output logic                 INTRQ,
  // Multi-sector configuration and progress
  output logic                 MULTI_ENABLE,
  output logic [4:0]           MULTI_BLOCK,
  input  wire logic            MULTI_ACTIVE,
  input  wire logic            SECTOR_DONE,
  input  wire logic            LAST_SECTOR,
  // Sector format
  input  wire dcss_desc_t [7:0] DESCRIPTORS,
  output logic                 LOGICAL_4K,
  output logic [3:0]           LOG_PER_PHYS,
  output logic [47:0]          USABLE_LBA_LIMIT,
  // Spindle and interface power
  input  wire logic            SPUN_DOWN,
  output logic                 SPIN_DOWN_REQ,
  output logic                 IFACE_ACTIVE,
  // Monitoring state
  output logic                 MONITOR_ENABLE,
  output logic                 AUTOSAVE_ENABLE,
  // Attribute page fill and stream
  input  wire logic            ATTR_WR_EN,
  input  wire logic [7:0]      ATTR_WR_ADDR,
  input  wire logic [15:0]     ATTR_WR_DATA,
  output logic                 DATA_VALID,
  output logic [15:0]          DATA_WORD,
  input  wire logic            DATA_READY
);

  typedef struct packed {
    dcss_state_t st;
    logic [7:0]  err;
    logic [7:0]  stat;
    logic        intrq;
    logic        pend_abort;
    logic        multi_en;
    logic [4:0]  blk;
    logic [4:0]  blk_cnt;
    logic        len4k;
    logic [3:0]  lps;
    logic [47:0] lba_limit;
    logic        spin_req;
    logic        iface;
    logic        mon_en;
    logic        autosave;
    logic        xfer_go;
  } dcss_core_t;

  dcss_core_t cur;
  dcss_core_t next_cur;
  logic       xfer_done;
  dcss_desc_t sel_desc;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Legal multi-sector block sizes
  function automatic logic blk_size_ok(input logic [7:0] n);
    return (n == 8'h00) || (n == 8'h01) || (n == 8'h02) || (n == 8'h04) || (n == 8'h08) || (n == 8'h10);
  endfunction

  // Listed monitoring subcommand codes
  function automatic logic sub_listed(input logic [7:0] f);
    return (f >= `DCSS_SUB_RD_VALUES && f <= `DCSS_SUB_WR_LOG) ||
           (f >= `DCSS_SUB_ENABLE && f <= `DCSS_SUB_AUTO_OFFLINE);
  endfunction

  // Index sits in count bits 2-0; upper bits are ignored
  assign sel_desc = DESCRIPTORS[CMD.count[2:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Attribute streamer

  dcss_attr_xfer #(
    .WORDS (ATTR_WORDS)
  ) u_xfer (
    .clk        (CORE_CLK),
    .rst_n      (RSTN),
    .wr_en      (ATTR_WR_EN),
    .wr_addr    (ATTR_WR_ADDR),
    .wr_data    (ATTR_WR_DATA),
    .start      (cur.xfer_go),
    .done       (xfer_done),
    .data_valid (DATA_VALID),
    .data_word  (DATA_WORD),
    .data_ready (DATA_READY)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  // Commands are taken only in idle; busy blocks any new strobe meanwhile
  always_comb begin
    next_cur         = cur;
    next_cur.intrq   = 1'b0;
    next_cur.xfer_go = 1'b0;
    case (cur.st)
      DCSS_IDLE: begin
        // Per-block interrupt during a multi-sector transfer
        if (MULTI_ACTIVE && cur.multi_en && SECTOR_DONE) begin
          if ((cur.blk_cnt + 5'h01) == cur.blk || LAST_SECTOR) begin
            next_cur.intrq   = 1'b1;
            next_cur.blk_cnt = 5'h00;
          end else begin
            next_cur.blk_cnt = cur.blk_cnt + 5'h01;
          end
        end else if (!MULTI_ACTIVE) begin
          next_cur.blk_cnt = 5'h00;
        end
        if (CMD_STROBE) begin
          next_cur.err        = `DCSS_ERR_RESET;
          next_cur.stat       = 8'h00;
          next_cur.stat[`DCSS_ST_BUSY_BIT] = 1'b1;
          next_cur.pend_abort = 1'b0;
          next_cur.st         = DCSS_DONE;
          if (CMD.opcode == `DCSS_OP_SET_MULTI) begin
            if (blk_size_ok(CMD.count[7:0]) && CMD.count[15:8] == 8'h00) begin
              next_cur.multi_en = (CMD.count[7:0] != 8'h00);
              next_cur.blk      = CMD.count[4:0];
            end else begin
              next_cur.multi_en   = 1'b0;
              next_cur.pend_abort = 1'b1;
            end
          end else if (CMD.opcode == `DCSS_OP_SECT_CFG) begin
            // Check field must match the chosen descriptor, else the format is refused
            if (sel_desc.valid && sel_desc.check == CMD.feature &&
                (sel_desc.len_code == `DCSS_LEN_512 || sel_desc.len_code == `DCSS_LEN_4096)) begin
              next_cur.len4k     = (sel_desc.len_code == `DCSS_LEN_4096);
              next_cur.lps       = sel_desc.log_per_phys;
              next_cur.lba_limit = sel_desc.max_lba;
            end else begin
              next_cur.pend_abort = 1'b1;
            end
          end else if (CMD.opcode == `DCSS_OP_SLEEP_A || CMD.opcode == `DCSS_OP_SLEEP_B) begin
            if (SPUN_DOWN) begin
              next_cur.st = DCSS_SLEEP;
              next_cur.stat = `DCSS_STAT_RESET;
              next_cur.intrq = 1'b1;
              next_cur.iface = 1'b0;
            end else begin
              next_cur.st       = DCSS_SPIN;
              next_cur.spin_req = 1'b1;
            end
          end else if (CMD.opcode == `DCSS_OP_MONITOR) begin
            if (!sub_listed(CMD.feature[7:0])) begin
              next_cur.pend_abort = 1'b1;
            end else if (CMD.feature[7:0] == `DCSS_SUB_RD_VALUES) begin
              next_cur.st      = DCSS_XFER;
              next_cur.xfer_go = 1'b1;
              next_cur.stat[`DCSS_ST_BUSY_BIT] = 1'b0;
              next_cur.stat[`DCSS_ST_XFER_BIT] = 1'b1;
              next_cur.stat[`DCSS_ST_READY_BIT] = 1'b1;
            end else if (CMD.feature[7:0] == `DCSS_SUB_AUTOSAVE) begin
              // Only 00h and F1h are meaningful; others leave autosave alone
              if (CMD.count[7:0] == `DCSS_AUTOSAVE_OFF) begin
                next_cur.autosave = 1'b0;
              end else if (CMD.count[7:0] == `DCSS_AUTOSAVE_ON) begin
                next_cur.autosave = 1'b1;
              end else begin
                next_cur.pend_abort = 1'b1;
              end
            end else if (CMD.feature[7:0] == `DCSS_SUB_ENABLE) begin
              next_cur.mon_en = 1'b1;
            end else if (CMD.feature[7:0] == `DCSS_SUB_DISABLE) begin
              next_cur.mon_en   = 1'b0;
              next_cur.autosave = 1'b0;
            end
          end else begin
            // Opcodes outside this block are refused
            next_cur.pend_abort = 1'b1;
          end
        end
      end
      DCSS_DONE: begin
        // One busy cycle, then the outcome and an interrupt
        next_cur.st    = DCSS_IDLE;
        next_cur.stat  = `DCSS_STAT_RESET;
        next_cur.intrq = 1'b1;
        if (cur.pend_abort) begin
          next_cur.err[`DCSS_ERR_ABORT_BIT] = 1'b1;
          next_cur.stat[`DCSS_ST_ERR_BIT]   = 1'b1;
        end
      end
      DCSS_XFER: begin
        // Transfer request stays up until the last word is taken
        if (xfer_done) begin
          next_cur.st    = DCSS_IDLE;
          next_cur.stat  = `DCSS_STAT_RESET;
          next_cur.intrq = 1'b1;
        end
      end
      DCSS_SPIN: begin
        // Wait for the spindle to report stopped
        if (SPUN_DOWN) begin
          next_cur.spin_req = 1'b0;
          next_cur.st       = DCSS_SLEEP;
          next_cur.stat     = `DCSS_STAT_RESET;
          next_cur.intrq    = 1'b1;
          next_cur.iface    = 1'b0;
        end
      end
      DCSS_SLEEP: begin
        // Strobes are ignored here; only a reset brings the interface back
        if (SOFT_RESET) begin
          next_cur.st    = DCSS_IDLE;
          next_cur.iface = 1'b1;
          next_cur.err   = `DCSS_ERR_RESET;
          next_cur.stat  = `DCSS_STAT_RESET;
        end
      end
      default: begin
        next_cur.st = DCSS_IDLE;
      end
    endcase
  end

  // Hardware reset also ends sleep; configuration returns to defaults
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur        <= '0;
      cur.st     <= DCSS_IDLE;
      cur.stat   <= `DCSS_STAT_RESET;
      cur.iface  <= 1'b1;
      cur.mon_en <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign ERROR_FLAGS      = cur.err;
  assign STATUS_FLAGS     = cur.stat;
  assign INTRQ            = cur.intrq;
  assign MULTI_ENABLE     = cur.multi_en;
  assign MULTI_BLOCK      = cur.blk;
  assign LOGICAL_4K       = cur.len4k;
  assign LOG_PER_PHYS     = cur.lps;
  assign USABLE_LBA_LIMIT = cur.lba_limit;
  assign SPIN_DOWN_REQ    = cur.spin_req;
  assign IFACE_ACTIVE     = cur.iface;
  assign MONITOR_ENABLE   = cur.mon_en;
  assign AUTOSAVE_ENABLE  = cur.autosave;

endmodule

// ===== src/dcss_defines.svh
// Constants of the disk command block: opcodes, feature codes, field positions, reset values.
`ifndef DCSS_DEFINES_SVH
`define DCSS_DEFINES_SVH

// Opcodes
`define DCSS_OP_SET_MULTI     8'hC6
`define DCSS_OP_SECT_CFG      8'hB2
`define DCSS_OP_SLEEP_A       8'hE6
`define DCSS_OP_SLEEP_B       8'h99
`define DCSS_OP_MONITOR       8'hB0

// Monitoring subcommand codes
`define DCSS_SUB_RD_VALUES    8'hD0
`define DCSS_SUB_RD_THRESH    8'hD1
`define DCSS_SUB_AUTOSAVE     8'hD2
`define DCSS_SUB_SAVE_VALUES  8'hD3
`define DCSS_SUB_OFFLINE_IMM  8'hD4
`define DCSS_SUB_RD_LOG       8'hD5
`define DCSS_SUB_WR_LOG       8'hD6
`define DCSS_SUB_ENABLE       8'hD8
`define DCSS_SUB_DISABLE      8'hD9
`define DCSS_SUB_RET_STATUS   8'hDA
`define DCSS_SUB_AUTO_OFFLINE 8'hDB

// Autosave count codes
`define DCSS_AUTOSAVE_OFF     8'h00
`define DCSS_AUTOSAVE_ON      8'hF1

// Error and status bit positions
`define DCSS_ERR_ABORT_BIT    2
`define DCSS_ST_BUSY_BIT      7
`define DCSS_ST_READY_BIT     6
`define DCSS_ST_XFER_BIT      3
`define DCSS_ST_ERR_BIT       0

// Reset values
`define DCSS_ERR_RESET        8'h00
`define DCSS_STAT_RESET       8'h40

// Logical length codes in a descriptor
`define DCSS_LEN_512          2'h0
`define DCSS_LEN_4096         2'h1

// Attribute page: 512 bytes as 256 words of 16 bits
`define DCSS_ATTR_WORDS       256

`endif

// ===== src/dcss_pkg.sv
// Types shared by the disk command block.
package dcss_pkg;

  // One-hot command sequencer states
  typedef enum logic [4:0] {
    DCSS_IDLE  = 5'h01,
    DCSS_DONE  = 5'h02,
    DCSS_XFER  = 5'h04,
    DCSS_SPIN  = 5'h08,
    DCSS_SLEEP = 5'h10
  } dcss_state_t;

  // Sector configuration descriptor held by drive firmware
  typedef struct packed {
    logic        valid;
    logic [1:0]  len_code;
    logic [3:0]  log_per_phys;
    logic [15:0] check;
    logic [47:0] max_lba;
  } dcss_desc_t;

  // Task-file command as issued by the host
  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] feature;
    logic [15:0] count;
  } dcss_cmd_t;

endpackage

// ===== src/dcss_attr_xfer.sv
// Attribute page store and 512-byte word streamer toward the host.
`include "dcss_defines.svh"
module dcss_attr_xfer
  import dcss_pkg::*;
#(
  parameter int WORDS = `DCSS_ATTR_WORDS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Firmware write port into the page
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  // Control
  input  wire logic        start,
  output logic             done,
  // Word stream
  output logic             data_valid,
  output logic [15:0]      data_word,
  input  wire logic        data_ready
);

  typedef struct packed {
    logic        active;
    logic [7:0]  idx;
    logic [15:0] word;
    logic        done;
  } dcss_xfer_t;

  dcss_xfer_t  cur;
  dcss_xfer_t  next_cur;
  logic [15:0] page [WORDS];

  // Page contents are not reset; firmware fills them before use
  always_ff @(posedge clk) begin
    if (wr_en) begin
      page[wr_addr] <= wr_data;
    end
  end

  // Word advances only on an accepted handshake, so the host may stall freely
  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    if (!cur.active && start) begin
      next_cur.active = 1'b1;
      next_cur.idx    = 8'h00;
      next_cur.word   = page[0];
    end else if (cur.active && data_ready) begin
      if (cur.idx == 8'(WORDS - 1)) begin
        next_cur.active = 1'b0;
        next_cur.done   = 1'b1;
      end else begin
        next_cur.idx  = cur.idx + 8'h01;
        next_cur.word = page[cur.idx + 8'h01];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done       = cur.done;
  assign data_valid = cur.active;
  assign data_word  = cur.word;

endmodule

// ===== test/dcss_top_properties.sv
// Port checker for the disk command block
module dcss_top_properties
  import dcss_pkg::*;
(
  // Clock and resets
  input wire logic             CORE_CLK,
  input wire logic             RSTN,
  input wire logic             SOFT_RESET,
  // Command and answer
  input wire logic             CMD_STROBE,
  input wire dcss_cmd_t        CMD,
  input wire logic [7:0]       ERROR_FLAGS,
  input wire logic [7:0]       STATUS_FLAGS,
  input wire logic             INTRQ,
  // Configuration
  input wire logic             MULTI_ENABLE,
  input wire logic [4:0]       MULTI_BLOCK,
  input wire dcss_desc_t [7:0] DESCRIPTORS,
  input wire logic             LOGICAL_4K,
  input wire logic [3:0]       LOG_PER_PHYS,
  input wire logic [47:0]      USABLE_LBA_LIMIT,
  // Power and stream
  input wire logic             SPUN_DOWN,
  input wire logic             SPIN_DOWN_REQ,
  input wire logic             IFACE_ACTIVE,
  input wire logic             DATA_VALID,
  input wire logic [15:0]      DATA_WORD,
  input wire logic             DATA_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic       go, ok_cnt, ok_sub, ok_desc, slp;
  dcss_desc_t d;
  // Strobe that the block takes; interrupt cycles are left out, though the block is already idle there except on entry to sleep
  assign go = CMD_STROBE && IFACE_ACTIVE && !INTRQ && STATUS_FLAGS[7:1] == 7'h20;
  assign d = DESCRIPTORS[CMD.count[2:0]];
  assign ok_cnt = CMD.count inside {16'h0, 16'h1, 16'h2, 16'h4, 16'h8, 16'h10};
  assign ok_sub = CMD.feature[7:0] inside {[8'hD0:8'hD6], [8'hD8:8'hDB]};
  assign ok_desc = d.valid && d.check == CMD.feature && d.len_code < 2'h2;
  assign slp = CMD.opcode == 8'hE6 || CMD.opcode == 8'h99;
  // Command fields stay put until the next strobe, so CMD is read late
  a_multi_good: assert property (go && CMD.opcode == 8'hC6 && ok_cnt |-> ##1
    STATUS_FLAGS == 8'h80 ##1 INTRQ && ERROR_FLAGS == 8'h0 && MULTI_BLOCK == CMD.count[4:0] &&
    MULTI_ENABLE == (CMD.count != 16'h0)) else $error("block size not applied");
  a_multi_bad: assert property (go && CMD.opcode == 8'hC6 && !ok_cnt |-> ##2
    INTRQ && ERROR_FLAGS == 8'h4 && STATUS_FLAGS == 8'h41 && !MULTI_ENABLE) else $error("bad size kept");
  a_sect_good: assert property (go && CMD.opcode == 8'hB2 && ok_desc |-> ##2 INTRQ &&
    LOGICAL_4K == d.len_code[0] && LOG_PER_PHYS == d.log_per_phys && USABLE_LBA_LIMIT == d.max_lba)
    else $error("format not applied");
  a_sect_bad: assert property (go && CMD.opcode == 8'hB2 && !ok_desc |-> ##2
    ERROR_FLAGS == 8'h4 && STATUS_FLAGS == 8'h41) else $error("bad format taken");
  a_sleep_quick: assert property (go && slp && SPUN_DOWN |=>
    INTRQ && !IFACE_ACTIVE && !SPIN_DOWN_REQ) else $error("quick sleep wrong");
  a_sleep_spin: assert property (go && slp && !SPUN_DOWN |=> SPIN_DOWN_REQ && STATUS_FLAGS[7])
    else $error("no spin down");
  a_sleep_hold: assert property (!IFACE_ACTIVE && !SOFT_RESET |=> !IFACE_ACTIVE && !INTRQ)
    else $error("sleep left early");
  a_mon_bad: assert property (go && CMD.opcode == 8'hB0 && !ok_sub |-> ##2
    INTRQ && ERROR_FLAGS[2] && STATUS_FLAGS[0]) else $error("bad subcommand taken");
  a_read_go: assert property (go && CMD.opcode == 8'hB0 && CMD.feature[7:0] == 8'hD0 |=>
    STATUS_FLAGS == 8'h48 ##1 DATA_VALID) else $error("read did not start");
  a_word_hold: assert property (DATA_VALID && !DATA_READY |=> DATA_VALID && $stable(DATA_WORD))
    else $error("word dropped");
  // Main scenarios
  c_abort: cover property (INTRQ && ERROR_FLAGS[2]);
  c_word: cover property (DATA_VALID && DATA_READY);
  c_sleep: cover property ($fell(IFACE_ACTIVE));
endmodule
////////////////////////////////////////////////////////////////
bind dcss_top dcss_top_properties i_props (.CORE_CLK, .RSTN, .SOFT_RESET, .CMD_STROBE, .CMD, .ERROR_FLAGS,
  .STATUS_FLAGS, .INTRQ, .MULTI_ENABLE, .MULTI_BLOCK, .DESCRIPTORS, .LOGICAL_4K, .LOG_PER_PHYS,
  .USABLE_LBA_LIMIT, .SPUN_DOWN, .SPIN_DOWN_REQ, .IFACE_ACTIVE, .DATA_VALID, .DATA_WORD, .DATA_READY);

// ===== test/dcss_host_model.sv
// Far-side model: spindle and attribute word sink
module dcss_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Spindle
  input  wire logic        spin_req,
  output logic             spun_down,
  // Word sink; slow stalls three cycles in four
  input  wire logic        slow,
  input  wire logic        valid,
  input  wire logic [15:0] word,
  output logic             ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [256];
  logic [1:0]  cnt, sc;
  int          n;
  // Stall pattern and word capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      n <= 0;
      ready <= '0;
    end else begin
      cnt <= cnt + 2'h1;
      ready <= !slow || cnt == 2'h2;
      if (valid && ready) begin
        mem[n] <= word;
        n <= n + 1;
      end
    end
  end
  // Spindle takes a few cycles to stop, then stays down until reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc <= '0;
      spun_down <= '0;
    end else if (spin_req && !spun_down) begin
      sc <= sc + 2'h1;
      spun_down <= sc == 2'h3;
    end
  end
endmodule

// ===== test/dcss_top_tb_top.sv
// Self-checking testbench for the disk command block
module dcss_top_tb_top
  import dcss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK = '0, RSTN = '0, SOFT_RESET = '0, CMD_STROBE = '0, MULTI_ACTIVE = '0;
  logic SECTOR_DONE = '0, LAST_SECTOR = '0, ATTR_WR_EN = '0, slow = '0;
  logic INTRQ, MULTI_ENABLE, LOGICAL_4K, SPUN_DOWN, SPIN_DOWN_REQ, IFACE_ACTIVE;
  logic MONITOR_ENABLE, AUTOSAVE_ENABLE, DATA_VALID, DATA_READY;
  logic [7:0]       ATTR_WR_ADDR = '0, ERROR_FLAGS, STATUS_FLAGS, err, st;
  logic [15:0]      ATTR_WR_DATA = '0, DATA_WORD;
  logic [47:0]      USABLE_LBA_LIMIT;
  logic [4:0]       MULTI_BLOCK;
  logic [3:0]       LOG_PER_PHYS;
  dcss_cmd_t        CMD = '0;
  dcss_desc_t [7:0] DESCRIPTORS;
  int               fails = 0, checks = 0, irqs = 0;
  dcss_top i_dut (.CORE_CLK, .RSTN, .SOFT_RESET, .CMD_STROBE, .CMD, .ERROR_FLAGS, .STATUS_FLAGS, .INTRQ,
    .MULTI_ENABLE, .MULTI_BLOCK, .MULTI_ACTIVE, .SECTOR_DONE, .LAST_SECTOR, .DESCRIPTORS, .LOGICAL_4K,
    .LOG_PER_PHYS, .USABLE_LBA_LIMIT, .SPUN_DOWN, .SPIN_DOWN_REQ, .IFACE_ACTIVE, .MONITOR_ENABLE,
    .AUTOSAVE_ENABLE, .ATTR_WR_EN, .ATTR_WR_ADDR, .ATTR_WR_DATA, .DATA_VALID, .DATA_WORD, .DATA_READY);
  dcss_host_model i_host (.clk(CORE_CLK), .rst_n(RSTN), .spin_req(SPIN_DOWN_REQ), .spun_down(SPUN_DOWN),
    .slow, .valid(DATA_VALID), .word(DATA_WORD), .ready(DATA_READY));
  // Clock and interrupt tally; reads see pre-edge values, so no race
  always #20 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) if (INTRQ === 1'h1) irqs <= irqs + 1;
////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [47:0] s, logic [47:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Strobe one command, hold its fields, wait for the completion interrupt
  task automatic issue(logic [7:0] op, logic [15:0] f, logic [15:0] c);
    int k;
    @(posedge CORE_CLK);
    CMD_STROBE <= 1'h1;
    CMD <= '{op, f, c};
    @(posedge CORE_CLK);
    CMD_STROBE <= '0;
    for (k = 0; k < 3000 && INTRQ !== 1'h1; k++) @(posedge CORE_CLK);
    check("irq", k < 3000, 1'h1);
    err = ERROR_FLAGS;
    st = STATUS_FLAGS;
  endtask
  task automatic t_multi();
    logic [15:0] cl [9] = '{16'h0, 16'h1, 16'h2, 16'h4, 16'h8, 16'h10, 16'h3, 16'h11, 16'h104};
    for (int i = 0; i < 9; i++) begin
      issue(8'hC6, '0, cl[i]);
      check("multi_err", err, (i < 6) ? 8'h0 : 8'h4);
      check("multi_en", MULTI_ENABLE, i > 0 && i < 6);
      if (i < 6) check("multi_blk", MULTI_BLOCK, cl[i][4:0]);
    end
  endtask
  task automatic t_blocks();
    int n0;
    issue(8'hC6, '0, 16'h4);
    @(posedge CORE_CLK);
    n0 = irqs;
    MULTI_ACTIVE <= 1'h1;
    for (int i = 1; i <= 10; i++) begin
      @(posedge CORE_CLK);
      SECTOR_DONE <= 1'h1;
      LAST_SECTOR <= i == 10;
      @(posedge CORE_CLK);
      SECTOR_DONE <= '0;
    end
    repeat (3) @(posedge CORE_CLK);
    MULTI_ACTIVE <= '0;
    LAST_SECTOR <= '0;
    check("blk_irqs", irqs - n0, 3);
  endtask
  task automatic t_sector();
    issue(8'hB2, 16'h1234, 16'hFFF9);
    check("len4k", LOGICAL_4K, 1'h1);
    check("lpp", LOG_PER_PHYS, 4'h8);
    check("limit", USABLE_LBA_LIMIT, 48'h12345678);
    issue(8'hB2, 16'h1235, 16'h1);
    check("bad_check", err, 8'h4);
    issue(8'hB2, 16'h22, 16'h2);
    check("bad_desc", err, 8'h4);
    issue(8'hB2, 16'h33, 16'h3);
    check("bad_len", err, 8'h4);
    check("limit_kept", USABLE_LBA_LIMIT, 48'h12345678);
    issue(8'hB2, 16'h44, 16'h4);
    check("len512", LOGICAL_4K, '0);
    check("limit2", USABLE_LBA_LIMIT, 48'h100);
  endtask
  task automatic t_smart();
    logic [7:0] sc [11] = '{8'hD1, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD8, 8'hDA, 8'hDB, 8'hD7, 8'hCF, 8'hDC};
    check("mon_rst", MONITOR_ENABLE, 1'h1);
    for (int i = 0; i < 11; i++) begin
      issue(8'hB0, {8'h0, sc[i]}, '0);
      check("sub_err", err, (i < 8) ? 8'h0 : 8'h4);
      check("sub_st", st[0], i >= 8);
    end
    issue(8'hB0, 16'hD2, 16'hF1);
    check("autosave", AUTOSAVE_ENABLE, 1'h1);
    issue(8'hB0, 16'hD2, 16'h0);
    check("autosave_clr", AUTOSAVE_ENABLE, '0);
    issue(8'hB0, 16'hD2, 16'hF1);
    issue(8'hB0, 16'hD9, '0);
    check("autosave_off", AUTOSAVE_ENABLE, '0);
    check("mon_off", MONITOR_ENABLE, '0);
    issue(8'hB0, 16'hD8, '0);
    check("mon_on", MONITOR_ENABLE, 1'h1);
    issue(8'hB0, 16'hD2, 16'h5);
    check("autosave_bad", err, 8'h4);
  endtask
  task automatic t_read();
    for (int i = 0; i < 256; i++) begin
      @(posedge CORE_CLK);
      ATTR_WR_EN <= 1'h1;
      ATTR_WR_ADDR <= 8'(i);
      ATTR_WR_DATA <= {8'(i), ~8'(i)};
    end
    @(posedge CORE_CLK);
    ATTR_WR_EN <= '0;
    slow <= 1'h1;
    issue(8'hB0, 16'hD0, '0);
    check("rd_st", st, 8'h40);
    check("rd_n", i_host.n, 256);
    for (int i = 0; i < 256; i++) check("rd_word", i_host.mem[i], {8'(i), ~8'(i)});
  endtask
  task automatic t_sleep();
    int n0;
    issue(8'hE6, '0, '0);
    check("asleep", IFACE_ACTIVE, '0);
    @(posedge CORE_CLK);
    n0 = irqs;
    CMD_STROBE <= 1'h1;
    CMD <= '{8'hC6, 16'h0, 16'h8};
    @(posedge CORE_CLK);
    CMD_STROBE <= '0;
    repeat (6) @(posedge CORE_CLK);
    check("sleep_irq", irqs - n0, 0);
    check("sleep_blk", MULTI_BLOCK, 5'h4);
    SOFT_RESET <= 1'h1;
    @(posedge CORE_CLK);
    SOFT_RESET <= '0;
    repeat (2) @(posedge CORE_CLK);
    check("soft_wake", IFACE_ACTIVE, 1'h1);
    issue(8'h99, '0, '0);
    check("asleep2", IFACE_ACTIVE, '0);
    check("no_spin", SPIN_DOWN_REQ, '0);
    RSTN <= '0;
    repeat (2) @(posedge CORE_CLK);
    check("hw_wake", IFACE_ACTIVE, 1'h1);
    check("rst_st", STATUS_FLAGS, 8'h40);
    check("rst_blk", MULTI_BLOCK, 5'h0);
    RSTN <= 1'h1;
  endtask
  // Main sequence
  initial begin
    DESCRIPTORS = '0;
    DESCRIPTORS[1] = '{1'h1, 2'h1, 4'h8, 16'h1234, 48'h12345678};
    DESCRIPTORS[2] = '{1'h0, 2'h0, 4'h1, 16'h22, 48'h200};
    DESCRIPTORS[3] = '{1'h1, 2'h2, 4'h1, 16'h33, 48'h300};
    DESCRIPTORS[4] = '{1'h1, 2'h0, 4'h1, 16'h44, 48'h100};
    repeat (5) @(posedge CORE_CLK);
    RSTN <= 1'h1;
    t_multi();
    t_blocks();
    t_sector();
    t_smart();
    t_read();
    t_sleep();
    end_of_test();
  end
  // Watchdog, well beyond the roughly 1500 cycles the run needs
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    fails++;
    end_of_test();
  end
endmodule
